// ### rtl/prescale_if.sv
// carrier between the refresh timer and its clock prescaler
`timescale 1ns/1ps
interface prescale_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport ctrl (output clk_sel, input tick);
  modport div  (input clk_sel, output tick);
endinterface

// ### rtl/refresh_pkg.sv
// constants for the refresh timer and refresh control block
// What this block does
// - power-on reset alone clears control, status and count registers
// - refresh_enable low means no refresh; counter is plain 8-bit timer
// - with refresh on, refresh_mode picks periodic refresh or self-refresh
// - with wait enable, refresh inserts 1 to 4 states, external wait ignored
// - wait enable low means wait field ignored and no wait states
// - reserved and unused bits read zero; software writes zero there
// - compare_match_flag sets when count equals refresh_constant
// - flag clears only by reading it as 1 then writing 0
// - match with irq enable raises compare_match_irq; disabled suppresses it
// - clock select 0 stops; 1..7 pick clock divided by 2..4096
// - counter counts up on selected clock once selection is nonzero
// - a match clears the counter to zero as well as setting the flag
// - a match with refresh_enable high and refresh_mode low runs one refresh cycle if none is still running
// - counter is 8 bits wide; reads give it in the low byte
// - refresh_constant holds compare value, written with key 0x96
// - refresh_constant resets to 0x00ff on power-on reset only
// - wrong key or byte-sized writes to protected registers are dropped
// - byte and word reads allowed; word reads give zero upper byte
package refresh_pkg;
  // register indices on the register port
  localparam logic [1:0]  IDX_CONTROL   = 2'h0;
  localparam logic [1:0]  IDX_CTRL_STAT = 2'h1;
  localparam logic [1:0]  IDX_COUNT     = 2'h2;
  localparam logic [1:0]  IDX_CONSTANT  = 2'h3;
  // write keys in the upper byte
  localparam logic [7:0]  KEY_CONTROL   = 8'h5a;
  localparam logic [7:0]  KEY_CTRL_STAT = 8'ha5;
  localparam logic [7:0]  KEY_COUNT     = 8'h69;
  localparam logic [7:0]  KEY_CONSTANT  = 8'h96;
  // field positions
  localparam int          POS_RFSH_EN   = 7;
  localparam int          POS_RFSH_MODE = 6;
  localparam int          POS_WAIT_HI   = 5;
  localparam int          POS_WAIT_LO   = 4;
  localparam int          POS_CMF       = 7;
  localparam int          POS_COMPARE_MATCH_IRQ_ENABLE      = 6;
  localparam int          POS_CKS_HI    = 5;
  localparam int          POS_CKS_LO    = 3;
  // reset values
  localparam logic [7:0]  RST_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_CTRL_STAT = 8'h00;
  localparam logic [7:0]  RST_COUNT     = 8'h00;
  localparam logic [7:0]  RST_CONSTANT  = 8'hff;
  // prescaler divide masks, index is clock select (divisor minus one)
  localparam logic [11:0] DIV_MASK [8] = '{
    12'h000, 12'h001, 12'h007, 12'h01f,
    12'h07f, 12'h1ff, 12'h7ff, 12'hfff};
  // refresh cycle length without wait states, in clock cycles
  localparam logic [2:0]  CBR_BASE_CYC  = 3'h1;
endpackage

// ### rtl/refresh_prescaler.sv
// free-running prescaler giving one-cycle counter enables
`timescale 1ns/1ps
module refresh_prescaler
  import refresh_pkg::*;
(
  input  wire logic   i_mclk,
  input  wire logic   i_srst,
  prescale_if.div     pif
);
  logic [11:0] presc_ff;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      presc_ff <= 12'h000;
    end else begin
      presc_ff <= presc_ff + 12'h001;
    end
  end

  // select 0 gives no tick at all: the counter clock is stopped
  assign pif.tick = (pif.clk_sel != 3'h0) &&
    ((presc_ff & DIV_MASK[pif.clk_sel]) == DIV_MASK[pif.clk_sel]);

  AST_NO_TICK_STOPPED: assert property (@(posedge i_mclk)
    disable iff (i_srst) (pif.clk_sel == 3'h0) |-> !pif.tick)
    else $error("prescaler ticked with clock stopped");
endmodule

// ### rtl/refresh_timer_ctrl.sv
// refresh control, refresh timer and its protected registers
`timescale 1ns/1ps
module refresh_timer_ctrl
  import refresh_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic [1:0]  i_reg_idx,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_word,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  input  wire logic        i_refresh_wait_enable,
  output logic             o_cbr_active,
  output logic             o_self_refresh,
  output logic             o_compare_match_irq
);
  // ==========================================================
  // registers
  logic [7:0] control_ff;
  logic [7:0] ctrl_stat_ff;
  logic [7:0] count_ff;
  logic [7:0] constant_ff;
  logic       cmf_armed_ff;
  logic [2:0] cbr_left_ff;
  logic [15:0] rdata_ff;

  logic refresh_enable;
  logic refresh_mode;
  logic [1:0] wait_sel;
  logic compare_match_flag;
  logic compare_match_irq_enable;
  logic match;
  logic cbr_start;
  logic [2:0] nxt_cbr_len;
  logic wr_ok_control;
  logic wr_ok_stat;
  logic wr_ok_count;
  logic wr_ok_constant;

  prescale_if pif ();

  refresh_prescaler i_refresh_prescaler (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .pif    (pif.div)
  );

  assign refresh_enable = control_ff[POS_RFSH_EN];
  assign refresh_mode   = control_ff[POS_RFSH_MODE];
  assign wait_sel       = control_ff[POS_WAIT_HI:POS_WAIT_LO];
  assign compare_match_flag            = ctrl_stat_ff[POS_CMF];
  assign compare_match_irq_enable           = ctrl_stat_ff[POS_COMPARE_MATCH_IRQ_ENABLE];
  assign pif.clk_sel    = ctrl_stat_ff[POS_CKS_HI:POS_CKS_LO];

  // ==========================================================
  // protected write decode: word size and matching key only
  assign wr_ok_control  = i_reg_wr && i_reg_word &&
    i_reg_idx == IDX_CONTROL && i_reg_wdata[15:8] == KEY_CONTROL;
  assign wr_ok_stat     = i_reg_wr && i_reg_word &&
    i_reg_idx == IDX_CTRL_STAT && i_reg_wdata[15:8] == KEY_CTRL_STAT;
  assign wr_ok_count    = i_reg_wr && i_reg_word &&
    i_reg_idx == IDX_COUNT && i_reg_wdata[15:8] == KEY_COUNT;
  assign wr_ok_constant = i_reg_wr && i_reg_word &&
    i_reg_idx == IDX_CONSTANT && i_reg_wdata[15:8] == KEY_CONSTANT;

  // only power-on reset reaches these; manual reset is not wired in
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      control_ff <= RST_CONTROL;
    end else if (wr_ok_control) begin
      control_ff <= {i_reg_wdata[7:4], 4'h0};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      constant_ff <= RST_CONSTANT;
    end else if (wr_ok_constant) begin
      constant_ff <= i_reg_wdata[7:0];
    end
  end

  // ==========================================================
  // counter and compare
  assign match = pif.tick && (count_ff == constant_ff);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      count_ff <= RST_COUNT;
    end else if (wr_ok_count) begin
      count_ff <= i_reg_wdata[7:0];
    end else if (match) begin
      count_ff <= 8'h00;
    end else if (pif.tick) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // reading the flag as 1 arms the clear; any keyed word status write disarms
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cmf_armed_ff <= 1'b0;
    end else if (wr_ok_stat) begin
      cmf_armed_ff <= 1'b0;
    end else if (i_reg_rd && i_reg_idx == IDX_CTRL_STAT && compare_match_flag) begin
      cmf_armed_ff <= 1'b1;
    end
  end

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_stat_ff <= RST_CTRL_STAT;
    end else begin
      if (wr_ok_stat) begin
        ctrl_stat_ff[POS_COMPARE_MATCH_IRQ_ENABLE:POS_CKS_LO] <= i_reg_wdata[6:3];
      end
      if (match) begin
        ctrl_stat_ff[POS_CMF] <= 1'b1;
      end else if (wr_ok_stat && !i_reg_wdata[POS_CMF] &&
                   cmf_armed_ff) begin
        ctrl_stat_ff[POS_CMF] <= 1'b0;
      end
    end
  end

  assign o_compare_match_irq = compare_match_flag && compare_match_irq_enable;

  // ==========================================================
  // refresh cycle: length counted down, wait states fixed by field only while wait enable is high
  assign cbr_start = match && refresh_enable && !refresh_mode &&
                     cbr_left_ff == 3'h0;
  assign nxt_cbr_len = i_refresh_wait_enable ?
    CBR_BASE_CYC + {1'b0, wait_sel} + 3'h1 : CBR_BASE_CYC;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cbr_left_ff <= 3'h0;
    end else if (cbr_start) begin
      cbr_left_ff <= nxt_cbr_len;
    end else if (cbr_left_ff != 3'h0) begin
      cbr_left_ff <= cbr_left_ff - 3'h1;
    end
  end

  assign o_cbr_active   = cbr_left_ff != 3'h0;
  // leaving self-refresh needs enable kept 1 while mode goes 0
  assign o_self_refresh = refresh_enable && refresh_mode;

  // ==========================================================
  // read port: registered, upper byte always zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_ff <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_idx)
        IDX_CONTROL:   rdata_ff <= {8'h00, control_ff};
        IDX_CTRL_STAT: rdata_ff <= {8'h00, ctrl_stat_ff};
        IDX_COUNT:     rdata_ff <= {8'h00, count_ff};
        IDX_CONSTANT:  rdata_ff <= {8'h00, constant_ff};
        default:       rdata_ff <= 16'h0000;
      endcase
    end
  end
  assign o_reg_rdata = rdata_ff;

  // ==========================================================
  // checks
  AST_CMF_SET: assert property (@(posedge i_mclk)
    disable iff (i_srst) match |=> compare_match_flag)
    else $error("flag not set after match");
  AST_CNT_CLEAR: assert property (@(posedge i_mclk)
    disable iff (i_srst) match && !wr_ok_count |=> count_ff == 8'h00)
    else $error("counter not cleared on match");
  AST_CNT_INC: assert property (@(posedge i_mclk)
    disable iff (i_srst) pif.tick && !match && !wr_ok_count
    |=> count_ff == $past(count_ff) + 8'h01)
    else $error("counter did not step on tick");
  AST_BAD_KEY: assert property (@(posedge i_mclk)
    disable iff (i_srst) i_reg_wr && i_reg_idx == IDX_CONSTANT &&
    (!i_reg_word || i_reg_wdata[15:8] != KEY_CONSTANT)
    |=> $stable(constant_ff))
    else $error("unprotected write changed constant");
  AST_CMF_HOLD: assert property (@(posedge i_mclk)
    disable iff (i_srst) compare_match_flag && !cmf_armed_ff && !i_reg_rd |=> compare_match_flag)
    else $error("flag cleared without prior read");
  AST_IRQ_RISE: assert property (@(posedge i_mclk)
    disable iff (i_srst) match && compare_match_irq_enable && !wr_ok_stat
    |=> o_compare_match_irq)
    else $error("irq missing after enabled match");
  AST_CMF_CLEAR: assert property (@(posedge i_mclk)
    disable iff (i_srst) wr_ok_stat && !i_reg_wdata[POS_CMF] &&
    cmf_armed_ff && !match |=> !compare_match_flag)
    else $error("armed flag clear did not take");
  AST_CNT_LOAD: assert property (@(posedge i_mclk)
    disable iff (i_srst) wr_ok_count
    |=> count_ff == $past(i_reg_wdata[7:0]))
    else $error("keyed count write not loaded");
  AST_CTRL_KEY: assert property (@(posedge i_mclk)
    disable iff (i_srst) i_reg_wr && i_reg_idx == IDX_CONTROL &&
    (!i_reg_word || i_reg_wdata[15:8] != KEY_CONTROL)
    |=> $stable(control_ff))
    else $error("unprotected write changed control");
  AST_NO_REFRESH_OFF: assert property (@(posedge i_mclk)
    disable iff (i_srst) match && !refresh_enable
    |=> !$rose(o_cbr_active))
    else $error("refresh started while disabled");
  AST_CBR_START: assert property (@(posedge i_mclk)
    disable iff (i_srst) match && refresh_enable && !refresh_mode &&
    !o_cbr_active |=> o_cbr_active)
    else $error("refresh not started on match");
  AST_CBR_FOUR_WAIT: assert property (@(posedge i_mclk)
    disable iff (i_srst) cbr_start && i_refresh_wait_enable &&
    wait_sel == 2'h3 |=> o_cbr_active [*5] ##1 !o_cbr_active)
    else $error("refresh length wrong with four waits");
  AST_CBR_NO_WAIT: assert property (@(posedge i_mclk)
    disable iff (i_srst) cbr_start && !i_refresh_wait_enable
    |=> o_cbr_active ##1 !o_cbr_active)
    else $error("wait states inserted while disabled");
  AST_UPPER_ZERO: assert property (@(posedge i_mclk)
    disable iff (i_srst) i_reg_rd |=> o_reg_rdata[15:8] == 8'h00)
    else $error("upper read byte not zero");
  AST_RESET_VALS: assert property (@(posedge i_mclk)
    i_srst |=> constant_ff == RST_CONSTANT && control_ff == RST_CONTROL &&
    ctrl_stat_ff == RST_CTRL_STAT &&
    count_ff == RST_COUNT)
    else $error("reset values wrong");
endmodule

// ### testbench/dram_partner.sv
// behavioural dram side that times the refresh cycles it receives
`timescale 1ns/1ps
module dram_partner (
  input  wire logic i_mclk,
  input  wire logic i_cbr_active,
  input  wire logic i_self_refresh,
  output int        o_n_cbr,
  output int        o_len,
  output int        o_period,
  output int        o_cbr_in_self
);
  // ==========================================
  // refresh cycle timing
  int   run     = 0;
  int   gap     = 0;
  int   n_cbr   = 0;
  int   len     = 0;
  int   period  = 0;
  int   in_self = 0;
  logic prev    = 1'b0;

  assign o_n_cbr       = n_cbr;
  assign o_len         = len;
  assign o_period      = period;
  assign o_cbr_in_self = in_self;

  always @(posedge i_mclk) begin
    prev <= i_cbr_active;
    gap  <= gap + 1;
    if (i_cbr_active) begin
      run <= prev ? run + 1 : 1;
    end
    if (i_cbr_active && !prev) begin
      n_cbr  <= n_cbr + 1;
      period <= gap + 1;
      gap    <= 0;
    end
    if (!i_cbr_active && prev) begin
      len <= run;
    end
    // a refresh cycle while the dram refreshes itself would upset it
    if (i_cbr_active && i_self_refresh) begin
      in_self <= in_self + 1;
    end
  end
endmodule

// ### testbench/dram_refresh_timer_control_tb_top.sv
// self-checking bench for the refresh timer and refresh control block
`timescale 1ns/1ps
module dram_refresh_timer_control_tb_top
  import refresh_pkg::*;
;
  logic        mclk;
  logic        srst;
  logic [1:0]  reg_idx;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_word;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        wait_en;
  logic        cbr;
  logic        self_rf;
  logic        irq;
  int          n_cbr;
  int          len;
  int          period;
  int          cbr_in_self;
  int          n_errors;
  int          checks;
  int          cyc;
  int          dv [7] = '{2, 8, 32, 128, 512, 2048, 4096};
  refresh_timer_ctrl i_refresh_timer_ctrl (
    .i_mclk(mclk), .i_srst(srst), .i_reg_idx(reg_idx),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_word(reg_word),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_refresh_wait_enable(wait_en), .o_cbr_active(cbr),
    .o_self_refresh(self_rf), .o_compare_match_irq(irq));
  dram_partner i_dram_partner (
    .i_mclk(mclk), .i_cbr_active(cbr), .i_self_refresh(self_rf),
    .o_n_cbr(n_cbr), .o_len(len), .o_period(period),
    .o_cbr_in_self(cbr_in_self));
  // ==========================================
  // access tasks
  always #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] idx, input logic wd,
                    input logic [15:0] d);
    @(negedge mclk);
    reg_idx = idx;
    reg_word = wd;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] idx, input logic [15:0] exp);
    @(negedge mclk);
    reg_idx = idx;
    reg_word = 1'b1;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    chk({16'h0, reg_rdata}, {16'h0, exp});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one clock: the divider tests together need about 13700 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================
  // tests
  initial begin
    mclk = 0; srst = 1; reg_idx = 0; reg_wr = 0; reg_rd = 0;
    reg_word = 1; reg_wdata = 0; wait_en = 0;
    n_errors = 0; checks = 0; cyc = 0;
    repeat (3) @(negedge mclk);
    srst = 0;
    rd(IDX_CONTROL, 16'h0000);
    rd(IDX_CTRL_STAT, 16'h0000);
    rd(IDX_COUNT, 16'h0000);
    rd(IDX_CONSTANT, 16'h00ff);
    wr(IDX_CONSTANT, 1'b1, {KEY_CONTROL, 8'h10});
    wr(IDX_CONSTANT, 1'b0, {KEY_CONSTANT, 8'h10});
    rd(IDX_CONSTANT, 16'h00ff);
    wr(IDX_COUNT, 1'b1, {KEY_COUNT, 8'h05});
    rd(IDX_COUNT, 16'h0005);
    wr(IDX_CONTROL, 1'b1, {KEY_CONTROL, 8'h70});
    rd(IDX_CONTROL, 16'h0070);
    chk(self_rf, 1'b0);
    $display("test registers done");
    // timer alone: flag, irq and two-step flag clear
    wr(IDX_CONTROL, 1'b1, {KEY_CONTROL, 8'h00});
    wr(IDX_CONSTANT, 1'b1, {KEY_CONSTANT, 8'h03});
    // count left at 5 would have to wrap past 255 before matching 3
    wr(IDX_COUNT, 1'b1, {KEY_COUNT, 8'h00});
    wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 8'h48});
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge mclk);
    chk(irq, 1'b1);
    chk(n_cbr, 0);
    // clock stopped from here so no fresh match hides the clear
    wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 8'h40});
    chk(irq, 1'b1);
    wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 8'h00});
    @(negedge mclk);
    chk(irq, 1'b0);
    rd(IDX_CTRL_STAT, 16'h0080);
    wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 8'h40});
    chk(irq, 1'b0);
    rd(IDX_CTRL_STAT, 16'h0040);
    $display("test timer done");
    // self-refresh, then periodic refresh and wait states
    wr(IDX_CONTROL, 1'b1, {KEY_CONTROL, 8'hc0});
    wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 8'h08});
    repeat (40) @(negedge mclk);
    chk(self_rf, 1'b1);
    chk(n_cbr, 0);
    chk(cbr_in_self, 0);
    wr(IDX_CONTROL, 1'b1, {KEY_CONTROL, 8'h80});
    repeat (40) @(negedge mclk);
    chk(self_rf, 1'b0);
    chk(period, 8);
    chk(len, 1);
    wait_en = 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(IDX_CONTROL, 1'b1, {KEY_CONTROL, 2'b10, 2'(f), 4'h0});
      repeat (30) @(negedge mclk);
      chk(len, 2 + f);
    end
    wait_en = 1'b0;
    repeat (30) @(negedge mclk);
    chk(len, 1);
    $display("test refresh done");
    // every clock divider, matching on each tick
    wr(IDX_CONSTANT, 1'b1, {KEY_CONSTANT, 8'h00});
    // a nonzero count would run to 255 and wrap before matching 0
    wr(IDX_COUNT, 1'b1, {KEY_COUNT, 8'h00});
    for (int c = 1; c < 8; c++) begin
      wr(IDX_CTRL_STAT, 1'b1, {KEY_CTRL_STAT, 2'b00, 3'(c), 3'b000});
      repeat (2 * dv[c-1] + 6) @(negedge mclk);
      chk(period, dv[c-1]);
    end
    $display("test dividers done");
    close_out();
  end
endmodule
